//--- src/bcbs_consts.vh
// constants for the backplane control block slave
`ifndef BCBS_CONSTS_VH
`define BCBS_CONSTS_VH
`define BCBS_ID_SET_TIME    16'h26f3
`define BCBS_ID_WARM_BOOT   16'h270e
`define BCBS_ID_COLD_BOOT   16'h270f
`define BCBS_OFS_ID         3'h0
`define BCBS_OFS_YEAR       3'h1
`define BCBS_OFS_MONTH      3'h2
`define BCBS_OFS_DAY        3'h3
`define BCBS_OFS_HOUR       3'h4
`define BCBS_OFS_MIN        3'h5
`define BCBS_OFS_SEC        3'h6
`define BCBS_OFS_MSEC       3'h7
`define BCBS_MONTH_MIN      16'h0001
`define BCBS_MONTH_MAX      16'h000c
`define BCBS_DAY_MIN        16'h0001
`define BCBS_DAY_MAX        16'h001f
`define BCBS_HOUR_MAX       16'h0017
`define BCBS_MIN_MAX        16'h003b
`define BCBS_SEC_MAX        16'h003b
`define BCBS_MSEC_MAX       16'h03e7
`define BCBS_DB_AW          8
`define BCBS_DB_DEPTH       256
`define BCBS_CNT_W          16
`define BCBS_CFG_W          16
`define BCBS_CNT_ONE        16'h0001
`define BCBS_CNT_ZERO       16'h0000
`define BCBS_WORD_ZERO      16'h0000
`define BCBS_PORT_A         1'b0
`define BCBS_BYTE_ZERO      8'h00
`define BCBS_NUM_WORDS      8
`endif

//--- src/bcbs_top.v
// backplane control block interpreter and slave command engine
// Notes on behaviour
// - block id 9971 loads new date and time into the clock.
// - block id 9998 requests software restart with config reload.
// - block id 9999 requests full hardware reset.
// - one shared database, only one serial port active at once.
// - port settings and node parameters load from storage at startup.
// - master commands to our node are checked; only valid accepted.
// - accepted read with no restart pending fetches database word and builds response.
// - accepted write stores word into database and, with no restart pending, builds response in the same cycle.
// - response goes back to originating master after data handling.
// - activity counters kept in status for the host.
`timescale 1ns/100ps
`include "bcbs_consts.vh"
module bcbs_top (
    input  wire                     clk_i,
    input  wire                     arst_n_i,
    // backplane block words, one word per strobe
    input  wire                     blk_wr_i,
    input  wire [2:0]               blk_ofs_i,
    input  wire [15:0]              blk_data_i,
    input  wire                     blk_end_i,
    // nonvolatile configuration fetch
    output wire                     cfg_req_o,
    input  wire                     cfg_ack_i,
    input  wire [`BCBS_CFG_W-1:0]   cfg_port_i,
    input  wire [7:0]               cfg_node_i,
    input  wire                     cfg_sel_i,
    // master commands from the serial side
    input  wire                     cmd_valid_i,
    input  wire                     cmd_port_i,
    input  wire [7:0]               cmd_node_i,
    input  wire                     cmd_write_i,
    input  wire [`BCBS_DB_AW-1:0]   cmd_addr_i,
    input  wire [15:0]              cmd_data_i,
    input  wire                     cmd_ok_i,
    // responses
    output reg                      rsp_valid_o,
    output reg                      rsp_port_o,
    output reg                      rsp_write_o,
    output reg  [`BCBS_DB_AW-1:0]   rsp_addr_o,
    output reg  [15:0]              rsp_data_o,
    // status and clock
    output reg                      ready_o,
    output reg                      active_port_o,
    output reg  [`BCBS_CFG_W-1:0]   port_cfg_o,
    output reg  [7:0]               node_addr_o,
    output reg  [15:0]              year_o,
    output reg  [15:0]              month_o,
    output reg  [15:0]              day_o,
    output reg  [15:0]              hour_o,
    output reg  [15:0]              minute_o,
    output reg  [15:0]              second_o,
    output reg  [15:0]              msec_o,
    output reg                      time_set_o,
    output reg                      time_rej_o,
    output reg                      hw_reset_o,
    output reg  [`BCBS_CNT_W-1:0]   cnt_rx_o,
    output reg  [`BCBS_CNT_W-1:0]   cnt_rsp_o,
    output reg  [`BCBS_CNT_W-1:0]   cnt_err_o
);

    localparam ST_LOAD = 2'b00;
    localparam ST_RUN  = 2'b01;
    localparam ST_RSP  = 2'b10;

    // sequencer state and the held block id
    reg [1:0]  state_q;
    reg [15:0] blk_id_q;
    // field words of the block in flight, year at the low end
    reg [15:0] fld_q [`BCBS_OFS_YEAR:`BCBS_OFS_MSEC];
    // shared point store for both serial ports
    reg [15:0] db_mem [0:`BCBS_DB_DEPTH-1];
    // pending software restart, absorbed by the next load
    reg        warm_q;

    assign cfg_req_o = (state_q == ST_LOAD);

    // block assembly: words land by offset, the id word picks the type
    // the id is kept until the next word 0, so end may come late
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            blk_id_q <= `BCBS_WORD_ZERO;
        end else if (blk_wr_i && blk_ofs_i == `BCBS_OFS_ID) begin
            blk_id_q <= blk_data_i;
        end
    end

    // field words, no reset needed since validated before use
    // trade-off: no reset saves flops, so a block sent with missing
    // words after power-up is checked against unknown contents
    genvar g;
    generate
        for (g = `BCBS_OFS_YEAR; g < `BCBS_NUM_WORDS; g = g + 1) begin : g_fld
            always @(posedge clk_i) begin
                if (blk_wr_i && blk_ofs_i == g)
                    fld_q[g] <= blk_data_i;
            end
        end
    endgenerate

    // per-field range checks; the year is taken as sent
    wire month_ok = (fld_q[`BCBS_OFS_MONTH] >= `BCBS_MONTH_MIN) &&
                    (fld_q[`BCBS_OFS_MONTH] <= `BCBS_MONTH_MAX);
    wire day_ok   = (fld_q[`BCBS_OFS_DAY] >= `BCBS_DAY_MIN) &&
                    (fld_q[`BCBS_OFS_DAY] <= `BCBS_DAY_MAX);

    // hour, minute and second start at zero, only the top is checked
    wire hour_ok  = (fld_q[`BCBS_OFS_HOUR] <= `BCBS_HOUR_MAX);
    wire min_ok   = (fld_q[`BCBS_OFS_MIN] <= `BCBS_MIN_MAX);
    wire sec_ok   = (fld_q[`BCBS_OFS_SEC] <= `BCBS_SEC_MAX);

    // milliseconds: no day-per-month check, 31 is taken for any month
    wire msec_ok  = (fld_q[`BCBS_OFS_MSEC] <= `BCBS_MSEC_MAX);

    // all fields must pass; a partial load would tear the timestamp
    wire fld_ok = month_ok && day_ok && hour_ok &&
                  min_ok && sec_ok && msec_ok;

    // block type decode at end of block; unknown ids fall through
    // and are ignored, which covers blocks served elsewhere
    wire is_set  = blk_end_i && blk_id_q == `BCBS_ID_SET_TIME;
    wire is_warm = blk_end_i && blk_id_q == `BCBS_ID_WARM_BOOT;
    wire is_cold = blk_end_i && blk_id_q == `BCBS_ID_COLD_BOOT;

    // clock load; a bad field rejects the whole block, not part of it
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            year_o     <= `BCBS_WORD_ZERO;
            month_o    <= `BCBS_MONTH_MIN;
            day_o      <= `BCBS_DAY_MIN;
            hour_o     <= `BCBS_WORD_ZERO;
            minute_o   <= `BCBS_WORD_ZERO;
            second_o   <= `BCBS_WORD_ZERO;
            msec_o     <= `BCBS_WORD_ZERO;
        end else if (is_set && fld_ok) begin
            year_o   <= fld_q[`BCBS_OFS_YEAR];
            month_o  <= fld_q[`BCBS_OFS_MONTH];
            day_o    <= fld_q[`BCBS_OFS_DAY];
            hour_o   <= fld_q[`BCBS_OFS_HOUR];
            minute_o <= fld_q[`BCBS_OFS_MIN];
            second_o <= fld_q[`BCBS_OFS_SEC];
            msec_o   <= fld_q[`BCBS_OFS_MSEC];
        end
    end

    // outcome pulses for the host, one cycle each
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            time_set_o <= 1'b0;
            time_rej_o <= 1'b0;
        end else begin
            time_set_o <= is_set && fld_ok;
            time_rej_o <= is_set && !fld_ok;
        end
    end

    // cold boot: pulse out to the board reset, which resets us too
    // the pulse is left to the board; nothing here waits on it
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i)
            hw_reset_o <= 1'b0;
        else
            hw_reset_o <= is_cold;
    end

    // command qualification: node match, port active, frame ok
    // only the configured port may talk; the other is held off
    wire run_ok   = (state_q == ST_RUN);
    wire node_hit = (cmd_node_i == node_addr_o);
    wire port_hit = (cmd_port_i == active_port_o);
    wire frame_ok = cmd_ok_i;

    // accepted commands go on; the rest refused in run only bump the error counter
    wire cmd_acc = cmd_valid_i && run_ok && node_hit &&
                   port_hit && frame_ok;
    // commands while a response is pending fall outside run_ok and
    // are dropped uncounted, as the spacing rule forbids them
    wire cmd_bad = cmd_valid_i && run_ok && !cmd_acc;

    // shared database, single write port keeps both serial ports coherent
    always @(posedge clk_i) begin
        if (cmd_acc && cmd_write_i)
            db_mem[cmd_addr_i] <= cmd_data_i;
    end

    // read port of the shared store; a read and a write never meet,
    // as the engine takes one command at a time
    wire [15:0] db_rd_word = db_mem[cmd_addr_i];

    // response capture: a command accepted in run, no restart pending
    wire rsp_cap = run_ok && !(warm_q || is_warm) && cmd_acc;

    // response fields, held until the next accepted command with no restart pending
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rsp_port_o  <= 1'b0;
            rsp_write_o <= 1'b0;
            rsp_addr_o  <= `BCBS_BYTE_ZERO;
            rsp_data_o  <= `BCBS_WORD_ZERO;
        end else if (rsp_cap) begin
            rsp_port_o  <= cmd_port_i;
            rsp_write_o <= cmd_write_i;
            rsp_addr_o  <= cmd_addr_i;
            // a write echoes its data, a read returns the stored word
            rsp_data_o  <= cmd_write_i ? cmd_data_i : db_rd_word;
        end
    end

    // response strobe one cycle after capture, once data has settled
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i)
            rsp_valid_o <= 1'b0;
        else
            rsp_valid_o <= (state_q == ST_RSP);
    end

    // sequencer: config load, run, response
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q       <= ST_LOAD;
            warm_q        <= 1'b0;
            ready_o       <= 1'b0;
            port_cfg_o    <= `BCBS_WORD_ZERO;
            node_addr_o   <= `BCBS_BYTE_ZERO;
            active_port_o <= `BCBS_PORT_A;
        end else begin
            if (is_warm)
                warm_q <= 1'b1;
            case (state_q)
                ST_LOAD: begin
                    // wait for storage; commands are refused meanwhile
                    ready_o <= 1'b0;
                    if (cfg_ack_i) begin
                        port_cfg_o    <= cfg_port_i;
                        node_addr_o   <= cfg_node_i;
                        active_port_o <= cfg_sel_i;
                        warm_q        <= 1'b0;
                        ready_o       <= 1'b1;
                        state_q       <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    // a restart wins over a command in the same cycle
                    if (warm_q || is_warm) begin
                        ready_o <= 1'b0;
                        state_q <= ST_LOAD;
                    end else if (rsp_cap) begin
                        state_q <= ST_RSP;
                    end
                end
                ST_RSP: begin
                    // one cycle for the strobe, then back to run
                    state_q <= ST_RUN;
                end
                default: state_q <= ST_LOAD;
            endcase
        end
    end

    // activity counters, wrap at full scale; host must diff readings
    // accepted commands
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i)
            cnt_rx_o <= `BCBS_CNT_ZERO;
        else if (cmd_acc)
            cnt_rx_o <= cnt_rx_o + `BCBS_CNT_ONE;
    end

    // responses sent
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i)
            cnt_rsp_o <= `BCBS_CNT_ZERO;
        else if (state_q == ST_RSP)
            cnt_rsp_o <= cnt_rsp_o + `BCBS_CNT_ONE;
    end

    // refused commands
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i)
            cnt_err_o <= `BCBS_CNT_ZERO;
        else if (cmd_bad)
            cnt_err_o <= cnt_err_o + `BCBS_CNT_ONE;
    end

endmodule // bcbs_top

//--- tb/bcbs_cfg_store.sv
// configuration storage model answering the slave's load requests
`timescale 1ns/100ps
module bcbs_cfg_store #(
    parameter WAIT = 3
) (
    input  wire        clk_i,
    input  wire        arst_n_i,
    input  wire        cfg_req_i,
    output reg         cfg_ack_o,
    output reg  [15:0] cfg_port_o,
    output reg  [7:0]  cfg_node_o,
    output reg         cfg_sel_o
);
    reg [7:0] cnt_q;
    // answer a load request after WAIT+1 cycles, one pulse per request
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q <= 8'h00;
            cfg_ack_o <= 1'b0;
        end else begin
            cnt_q <= cfg_req_i && !cfg_ack_o ? cnt_q + 8'h01 : 8'h00;
            cfg_ack_o <= cfg_req_i && !cfg_ack_o && cnt_q == WAIT;
        end
    end
    // fields inverted outside the ack so stale values never look valid
    always @* begin
        {cfg_port_o, cfg_node_o, cfg_sel_o} = cfg_ack_o ?
            {16'h0c35, 8'h5a, 1'b1} : ~{16'h0c35, 8'h5a, 1'b1};
    end
endmodule // bcbs_cfg_store

//--- tb/bcbs_sva.sv
// concurrent checks on the control block slave ports
`timescale 1ns/100ps
module bcbs_sva (
    input wire        clk_i,
    input wire        arst_n_i,
    input wire        blk_wr_i,
    input wire [2:0]  blk_ofs_i,
    input wire [15:0] blk_data_i,
    input wire        blk_end_i,
    input wire        cfg_req_o,
    input wire        cfg_ack_i,
    input wire [7:0]  cfg_node_i,
    input wire        cmd_valid_i,
    input wire [7:0]  cmd_node_i,
    input wire        rsp_valid_o,
    input wire        ready_o,
    input wire [7:0]  node_addr_o,
    input wire [15:0] month_o,
    input wire        time_set_o,
    input wire        time_rej_o,
    input wire        hw_reset_o,
    input wire [15:0] cnt_rx_o,
    input wire [15:0] cnt_rsp_o,
    input wire [15:0] cnt_err_o
);
    reg  [15:0] w_q [0:7];
    wire        set_end = blk_end_i && w_q[0] == 16'h26f3;
    // every field but the year is range checked
    wire        ok = w_q[2] >= 16'h1 && w_q[2] <= 16'hc && w_q[3] >= 16'h1
                && w_q[3] <= 16'h1f && w_q[4] <= 16'h17 && w_q[5] <= 16'h3b
                && w_q[6] <= 16'h3b && w_q[7] <= 16'h3e7;
    // mirror of block words so the id is known at blk_end_i
    always @(posedge clk_i) if (blk_wr_i) w_q[blk_ofs_i] <= blk_data_i;
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    time_set_a: assert property (set_end && ok |=> time_set_o
        && month_o == w_q[2]) else $error("valid time not loaded");
    time_keep_a: assert property (set_end && !ok |=> time_rej_o
        && !time_set_o && $stable(month_o)) else $error("bad time applied");
    cold_pulse_a: assert property (blk_end_i && w_q[0] == 16'h270f
        |=> hw_reset_o ##1 !hw_reset_o) else $error("no reset pulse");
    warm_boot_a: assert property (blk_end_i && w_q[0] == 16'h270e
        && ready_o |-> ##[1:2] !ready_o && cfg_req_o) else $error("no reload");
    cfg_load_a: assert property (cfg_req_o && cfg_ack_i |=> ready_o
        && node_addr_o == $past(cfg_node_i)) else $error("config not taken");
    cmd_rsp_a: assert property (cnt_rx_o == $past(cnt_rx_o) + 16'h1
        |=> rsp_valid_o && cnt_rsp_o == $past(cnt_rsp_o) + 16'h1)
        else $error("no response");
    cmd_rej_a: assert property (cmd_valid_i && ready_o
        && cmd_node_i != node_addr_o && $stable(cnt_rx_o)
        |=> cnt_err_o == $past(cnt_err_o) + 16'h1) else $error("no reject");
    rsp_count_a: assert property (cnt_rsp_o == $past(cnt_rsp_o) + 16'h1
        |-> rsp_valid_o) else $error("count without response");
endmodule // bcbs_sva

//--- tb/tb.sv
// self-checking bench for the control block slave
`timescale 1ns/100ps
module tb;
    reg         clk_i, arst_n_i, blk_wr_i, blk_end_i, cmd_valid_i, cmd_port_i;
    reg         cmd_write_i, cmd_ok_i;
    reg  [2:0]  blk_ofs_i;
    reg  [7:0]  cmd_node_i, cmd_addr_i;
    reg  [15:0] blk_data_i, cmd_data_i;
    wire        cfg_req_o, cfg_ack_i, cfg_sel_i, rsp_valid_o, rsp_port_o;
    wire        rsp_write_o, ready_o, active_port_o, time_set_o, time_rej_o;
    wire        hw_reset_o;
    wire [7:0]  cfg_node_i, node_addr_o, rsp_addr_o;
    wire [15:0] cfg_port_i, port_cfg_o, rsp_data_o, year_o, month_o, day_o;
    wire [15:0] hour_o, minute_o, second_o, msec_o, cnt_rx_o, cnt_rsp_o;
    wire [15:0] cnt_err_o;
    integer     errors, checks_done, n;
    bcbs_top i_dut (.clk_i, .arst_n_i, .blk_wr_i, .blk_ofs_i, .blk_data_i,
        .blk_end_i, .cfg_req_o, .cfg_ack_i, .cfg_port_i, .cfg_node_i,
        .cfg_sel_i, .cmd_valid_i, .cmd_port_i, .cmd_node_i, .cmd_write_i,
        .cmd_addr_i, .cmd_data_i, .cmd_ok_i, .rsp_valid_o, .rsp_port_o,
        .rsp_write_o, .rsp_addr_o, .rsp_data_o, .ready_o, .active_port_o,
        .port_cfg_o, .node_addr_o, .year_o, .month_o, .day_o, .hour_o,
        .minute_o, .second_o, .msec_o, .time_set_o, .time_rej_o,
        .hw_reset_o, .cnt_rx_o, .cnt_rsp_o, .cnt_err_o);
    bcbs_cfg_store #(.WAIT(3)) i_cfg (.clk_i, .arst_n_i,
        .cfg_req_i(cfg_req_o), .cfg_ack_o(cfg_ack_i), .cfg_port_o(cfg_port_i),
        .cfg_node_o(cfg_node_i), .cfg_sel_o(cfg_sel_i));
    // 20 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // inputs move 2 ns after the edge, clear of sampling
    task step;
        @(posedge clk_i);
        #2;
    endtask
    task check(input [63:0] got, input [63:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("[FAIL] %0t ns got %h want %h", $time, got, exp);
        end
    endtask
    // bounded wait for the load to finish
    task wait_ready;
        for (n = 0; n < 40 && ready_o !== 1'b1; n = n + 1) step;
        if (ready_o !== 1'b1) begin
            errors = errors + 1;
            close_out;
        end
    endtask
    task blk(input [15:0] id, input [15:0] mo, input [15:0] dy,
             input [15:0] ms);
        for (n = 0; n < 8; n = n + 1) begin
            blk_wr_i = 1'b1;
            blk_ofs_i = n[2:0];
            blk_data_i = n == 0 ? id : n == 1 ? 16'h07e9 : n == 2 ? mo
                : n == 3 ? dy : n == 4 ? 16'h0017 : n == 7 ? ms : 16'h003b;
            step;
        end
        blk_wr_i = 1'b0;
        blk_end_i = 1'b1;
        step;
        blk_end_i = 1'b0;
    endtask
    // one command pulse, returns in the cycle the response should stand
    task cmd(input p, input [7:0] nd, input w, input [15:0] d, input ok);
        {cmd_port_i, cmd_node_i, cmd_write_i} = {p, nd, w};
        {cmd_addr_i, cmd_data_i, cmd_ok_i} = {8'h10, d, ok};
        cmd_valid_i = 1'b1;
        step;
        cmd_valid_i = 1'b0;
        cmd_data_i = ~d;
        step;
    endtask
    task t_load;
        wait_ready;
        check({node_addr_o, port_cfg_o}, {8'h5a, 16'h0c35});
        check(active_port_o, 1'b1);
    endtask
    task t_time;
        blk(16'h26f3, 16'h000c, 16'h001f, 16'h03e7);
        check({time_set_o, year_o, month_o}, {1'b1, 16'h07e9, 16'h000c});
        check({day_o, hour_o, msec_o}, {16'h001f, 16'h0017, 16'h03e7});
        check({minute_o, second_o}, {16'h003b, 16'h003b});
        blk(16'h26f3, 16'h000d, 16'h0001, 16'h0000);
        check({time_rej_o, month_o}, {1'b1, 16'h000c});
        blk(16'h26f3, 16'h0001, 16'h0000, 16'h03e8);
        check({time_rej_o, day_o, msec_o}, {1'b1, 16'h001f, 16'h03e7});
        blk(16'h26f2, 16'h0001, 16'h0001, 16'h0000);
        check({time_set_o, time_rej_o, month_o}, 18'h0000c);
    endtask
    task t_cmd;
        cmd(1'b1, 8'h5a, 1'b1, 16'hbeef, 1'b1);
        check({rsp_valid_o, rsp_write_o, rsp_addr_o, rsp_data_o},
              {2'b11, 8'h10, 16'hbeef});
        check(rsp_port_o, 1'b1);
        cmd(1'b1, 8'h5a, 1'b0, 16'h0000, 1'b1);
        check({rsp_valid_o, rsp_write_o, rsp_data_o}, {2'b10, 16'hbeef});
        cmd(1'b1, 8'ha5, 1'b1, 16'h1111, 1'b1);
        cmd(1'b1, 8'h5a, 1'b1, 16'h2222, 1'b0);
        cmd(1'b0, 8'h5a, 1'b1, 16'h3333, 1'b1);
        check(rsp_valid_o, 1'b0);
        cmd(1'b1, 8'h5a, 1'b0, 16'h0000, 1'b1);
        check(rsp_data_o, 16'hbeef);
        check({cnt_rx_o, cnt_rsp_o, cnt_err_o}, {16'h3, 16'h3, 16'h3});
    endtask
    task t_boot;
        blk(16'h270e, 16'h0000, 16'h0000, 16'h0000);
        step;
        check({ready_o, cfg_req_o}, 2'b01);
        wait_ready;
        blk(16'h270f, 16'h0000, 16'h0000, 16'h0000);
        check(hw_reset_o, 1'b1);
        step;
        check(hw_reset_o, 1'b0);
    endtask
    task close_out;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // reset for 8 cycles, then the scenarios in turn
    initial begin
        {arst_n_i, blk_wr_i, blk_end_i, cmd_valid_i, cmd_port_i} = 5'h00;
        {cmd_write_i, cmd_ok_i, blk_ofs_i, cmd_node_i, cmd_addr_i} = 21'h0;
        {blk_data_i, cmd_data_i} = 32'h0;
        errors = 0;
        checks_done = 0;
        repeat (8) @(posedge clk_i);
        #2 arst_n_i = 1'b1;
        t_load;
        t_time;
        t_cmd;
        t_boot;
        close_out;
    end
endmodule // tb
bind bcbs_top bcbs_sva i_sva (.clk_i, .arst_n_i, .blk_wr_i, .blk_ofs_i,
    .blk_data_i, .blk_end_i, .cfg_req_o, .cfg_ack_i, .cfg_node_i,
    .cmd_valid_i, .cmd_node_i, .rsp_valid_o, .ready_o, .node_addr_o,
    .month_o, .time_set_o, .time_rej_o, .hw_reset_o, .cnt_rx_o,
    .cnt_rsp_o, .cnt_err_o);
